//--- src/true_random_generator.sv
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "true_random_generator_cfg.svh"
module true_random_generator
   import random_word_pkg::*;
(
   input  wire logic        ref_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             irq_o
);
   localparam logic [6:0] LAST_CNT = 7'(`WORD_PERIOD_CYCLES - 1);

   logic        aw_held;
   logic [7:0]  aw_addr;
   logic        w_held;
   word_t       w_data;
   logic [3:0]  w_strb;
   logic        gen_enable;
   logic [6:0]  period_cnt;
   word_t       out_word;
   logic        ready_flag;
   logic        mask_bit;
   word_t       mix_state;
   logic        wr_fire;
   logic        rd_fire;
   logic        word_done;
   logic        key_ok;
   logic        status_read;
   word_t       next_rdata;
   resp_t       next_rresp;
   logic        ctrl_write;
   logic        set_write;
   logic        clear_write;

   function automatic logic mapped(input logic [7:0] a, input logic wr);
      if (wr)
         return a == `OFS_KEYED_CONTROL || a == `OFS_IRQ_ENABLE_SET
             || a == `OFS_IRQ_ENABLE_CLEAR;
      return a == `OFS_IRQ_MASK_VIEW || a == `OFS_IRQ_STATUS_FLAGS
          || a == `OFS_RANDOM_OUTPUT || a == `OFS_MODULE_REVISION;
   endfunction

   entropy_lfsr u_src (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .run_i     (1'b1),
      .state_o   (mix_state)
   );

   // write channels held independently until both present
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         w_held <= 1'b0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
      end else begin
         s_axi_awready <= !(aw_held || (s_axi_awvalid && s_axi_awready))
                          || wr_fire;
         s_axi_wready  <= !(w_held || (s_axi_wvalid && s_axi_wready))
                          || wr_fire;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= mapped(aw_addr, 1'b1) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // key checked in bits 31:8 with all four strobes; partial strobes cannot carry the key
   assign key_ok = w_data[`KEY_MSB:`KEY_LSB] == `KEY_VALUE
                   && w_strb == 4'hF;

   assign ctrl_write  = wr_fire && aw_addr == `OFS_KEYED_CONTROL && key_ok;
   assign set_write   = wr_fire && aw_addr == `OFS_IRQ_ENABLE_SET;
   assign clear_write = wr_fire && aw_addr == `OFS_IRQ_ENABLE_CLEAR;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gen_enable <= 1'b0;
      end else if (ctrl_write) begin
         gen_enable <= w_data[`ENABLE_BIT];
      end
   end

   assign word_done = gen_enable && period_cnt == LAST_CNT;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         period_cnt <= 7'h0;
      end else if (!gen_enable) begin
         period_cnt <= 7'h0;
      end else if (word_done) begin
         period_cnt <= 7'h0;
      end else begin
         period_cnt <= period_cnt + 7'h1;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         out_word <= 32'h0;
      end else if (word_done) begin
         out_word <= mix_state;
      end
   end

   assign status_read = rd_fire && s_axi_araddr == `OFS_IRQ_STATUS_FLAGS;

   // a new word in the same cycle as the status read wins
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ready_flag <= 1'b0;
      end else if (word_done) begin
         ready_flag <= 1'b1;
      end else if (ctrl_write && !w_data[`ENABLE_BIT]) begin
         ready_flag <= 1'b0;
      end else if (!gen_enable) begin
         ready_flag <= 1'b0;
      end else if (status_read) begin
         ready_flag <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mask_bit <= 1'b0;
      end else if (wr_fire && aw_addr == `OFS_IRQ_ENABLE_SET
                   && w_data[`READY_BIT]) begin
         mask_bit <= 1'b1;
      end else if (wr_fire && aw_addr == `OFS_IRQ_ENABLE_CLEAR
                   && w_data[`READY_BIT]) begin
         mask_bit <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= ready_flag && mask_bit;
      end
   end

   always_comb begin
      next_rdata = 32'h0;
      next_rresp = `RESP_OKAY;
      unique case (s_axi_araddr)
         `OFS_IRQ_MASK_VIEW:    next_rdata[`READY_BIT] = mask_bit;
         `OFS_IRQ_STATUS_FLAGS: next_rdata[`READY_BIT] = ready_flag;
         `OFS_RANDOM_OUTPUT:    next_rdata = out_word;
         `OFS_MODULE_REVISION:  next_rdata = `REVISION_VALUE;
         default:               next_rresp = `RESP_SLVERR;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= `RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= next_rresp;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
      end
   end

   logic [7:0] gap_cnt;
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) gap_cnt <= 8'h0;
      else if (word_done || !gen_enable) gap_cnt <= 8'h0;
      else gap_cnt <= gap_cnt + 8'h1;
   end

   sequence s_word_out;
      word_done ##1 ready_flag;
   endsequence

   sequence s_keyed_stop;
      ctrl_write && !w_data[`ENABLE_BIT] && !word_done;
   endsequence

   a_word_period: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      word_done |-> gap_cnt == 8'(`WORD_PERIOD_CYCLES - 1))
      else $error("word period is not 84 cycles");

   a_key_guard: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      $changed(gen_enable) |-> $past(wr_fire && key_ok
         && aw_addr == `OFS_KEYED_CONTROL))
      else $error("enable changed without keyed write");

   a_key_refuse: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      wr_fire && aw_addr == `OFS_KEYED_CONTROL && !key_ok
      |=> $stable(gen_enable))
      else $error("control write without key took effect");

   a_enable_start: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (wr_fire && key_ok && aw_addr == `OFS_KEYED_CONTROL)
      |=> gen_enable == $past(w_data[`ENABLE_BIT]))
      else $error("keyed write did not set enable");

   a_stop_clears: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_keyed_stop |=> (!gen_enable && !ready_flag) ##1 !irq_o)
      else $error("stop write left generator running");

   a_irq_level: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_word_out ##0 mask_bit |=> irq_o)
      else $error("interrupt missing after new word");

   a_irq_quiet: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      !(ready_flag && mask_bit) |=> !irq_o)
      else $error("interrupt without ready flag and mask");

   a_status_clear: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      status_read && !word_done |=> !ready_flag ##1 !irq_o)
      else $error("status read did not clear ready");

   a_ready_off: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      !gen_enable && !$past(word_done) |-> !ready_flag)
      else $error("ready set while disabled");

   a_ready_set: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      word_done |=> ready_flag)
      else $error("ready flag not set by new word");

   a_mask_set: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      wr_fire && aw_addr == `OFS_IRQ_ENABLE_SET && w_data[0] |=> mask_bit)
      else $error("mask not set");

   a_mask_clear: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      wr_fire && aw_addr == `OFS_IRQ_ENABLE_CLEAR && w_data[0] |=> !mask_bit)
      else $error("mask not cleared");

   a_mask_keep: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (set_write || clear_write) && !w_data[`READY_BIT]
      |=> $stable(mask_bit))
      else $error("zero bit changed the mask");

   a_data_latest: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      word_done |=> out_word == $past(mix_state))
      else $error("output word not latest");

   a_data_read: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      rd_fire && s_axi_araddr == `OFS_RANDOM_OUTPUT
      |=> s_axi_rdata == $past(out_word))
      else $error("output read returned stale word");

   a_status_view: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      status_read |=> s_axi_rdata == {31'h0, $past(ready_flag)})
      else $error("status read shows wrong bits");

   a_restart_full: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      $rose(gen_enable) |-> period_cnt == 7'h0)
      else $error("counter not restarted");

   a_count_halt: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      !gen_enable |=> period_cnt == 7'h0)
      else $error("counter runs while disabled");

   a_write_hold: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");

   a_read_hold: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before taken");

   a_read_busy: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_axi_rvalid |-> !s_axi_arready)
      else $error("read address accepted while data pending");

   a_write_err: assert property (
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      wr_fire && !mapped(aw_addr, 1'b1)
      |=> s_axi_bresp == `RESP_SLVERR)
      else $error("unmapped write not refused");
endmodule

//--- src/true_random_generator_cfg.svh
// Overview of operation
// - while enabled, a fresh 32-bit word is ready every 84 clock cycles
// - control writes take effect only with key 0x524E47 in the key field
// - keyed write with enable one starts generation, zero stops it
// - interrupt asserts when a new word is ready and mask bit set
// - reading the status register clears the value-ready flag
// - ready flag is zero when data invalid or disabled, one when complete
// - writing one to enable-set register sets the mask bit
// - writing one to enable-clear register clears the mask bit
// - output data register returns the latest generated 32-bit word
`ifndef RANDOM_WORD_CFG_SVH
`define RANDOM_WORD_CFG_SVH
`define OFS_KEYED_CONTROL    8'h00
`define OFS_IRQ_ENABLE_SET   8'h10
`define OFS_IRQ_ENABLE_CLEAR 8'h14
`define OFS_IRQ_MASK_VIEW    8'h18
`define OFS_IRQ_STATUS_FLAGS 8'h1C
`define OFS_RANDOM_OUTPUT    8'h50
`define OFS_MODULE_REVISION  8'hFC
`define KEY_MSB              31
`define KEY_LSB              8
`define KEY_VALUE            24'h524E47
`define ENABLE_BIT           0
`define READY_BIT            0
`define WORD_PERIOD_CYCLES   84
`define PERIOD_CNT_W         7
// revision code value is arbitrary
`define REVISION_VALUE       32'h00000A01
`define RESP_OKAY            2'b00
`define RESP_SLVERR          2'b10
`endif

//--- src/true_random_generator_pkg.sv
package random_word_pkg;
   typedef logic [31:0] word_t;
   typedef logic [1:0]  resp_t;
endpackage

//--- src/entropy_lfsr.sv
`timescale 1ns/1ps
// free-running mixing source; a real part substitutes a noise source
module entropy_lfsr (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        run_i,
   output logic [31:0]      state_o
);
   logic [31:0] lfsr;
   logic [31:0] weyl;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lfsr <= 32'hACE1_2468;
         weyl <= 32'h0;
      end else if (run_i) begin
         lfsr <= {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
         weyl <= weyl + 32'h9E37_79B9;
      end
   end

   assign state_o = lfsr ^ {weyl[15:0], weyl[31:16]};
endmodule

//--- bench/true_random_generator_tb.sv
`timescale 1ns/1ps
`include "true_random_generator_cfg.svh"
module true_random_generator_tb;
   import random_word_pkg::*;
   logic ref_clk_i = 1'b0, rst_n_i = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'h0;
   logic        awready, wready, bvalid, arready, rvalid, irq_o;
   resp_t       bresp, rresp;
   word_t       rdata, rd, w1;
   resp_t       rs;
   int          num_errors = 0, compares = 0, cyc = 0, t1, t2;
   true_random_generator dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .irq_o(irq_o));
   always #10 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) cyc <= cyc + 1;
   task automatic results();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input word_t e, input word_t g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input word_t d, output resp_t r);
      int n;
      n = 0;
      @(posedge ref_clk_i);
      awaddr <= a; wdata <= d; wstrb <= 4'hF;
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid && n < 50);
      r = bresp;
      bready <= 1'b0;
      if (n >= 50) chk("write timeout", 32'h1, 32'h0);
   endtask
   task automatic rdr(input logic [7:0] a, output word_t d, output resp_t r);
      int n;
      n = 0;
      @(posedge ref_clk_i);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid && n < 50);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (n >= 50) chk("read timeout", 32'h1, 32'h0);
   endtask
   task automatic wait_irq(output int t);
      int n;
      n = 0;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (irq_o !== 1'b1 && n < 200);
      t = cyc;
      if (n >= 200) chk("irq timeout", 32'h1, 32'h0);
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      num_errors++;
      results();
   end
   initial begin
      repeat (6) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      rdr(`OFS_IRQ_MASK_VIEW, rd, rs);
      chk("mask reset", 32'h0, rd);
      rdr(`OFS_IRQ_STATUS_FLAGS, rd, rs);
      chk("status reset", 32'h0, rd);
      rdr(`OFS_RANDOM_OUTPUT, rd, rs);
      chk("output reset", 32'h0, rd);
      rdr(`OFS_MODULE_REVISION, rd, rs);
      chk("revision", `REVISION_VALUE, rd);
      rdr(8'h04, rd, rs);
      chk("unmapped resp", 32'h2, {30'h0, rs});
      chk("unmapped data", 32'h0, rd);
      wr(`OFS_IRQ_MASK_VIEW, 32'h1, rs);
      chk("ro resp", 32'h2, {30'h0, rs});
      wr(`OFS_IRQ_ENABLE_SET, 32'hFFFF_FFFE, rs);
      rdr(`OFS_IRQ_MASK_VIEW, rd, rs);
      chk("mask zero set", 32'h0, rd);
      wr(`OFS_IRQ_ENABLE_SET, 32'h1, rs);
      rdr(`OFS_IRQ_MASK_VIEW, rd, rs);
      chk("mask set", 32'h1, rd);
      wr(`OFS_KEYED_CONTROL, 32'h524E_4601, rs);
      chk("bad key resp", 32'h0, {30'h0, rs});
      repeat (100) @(posedge ref_clk_i);
      rdr(`OFS_IRQ_STATUS_FLAGS, rd, rs);
      chk("bad key", 32'h0, rd);
      chk("irq bad key", 32'h0, {31'h0, irq_o});
      wr(`OFS_KEYED_CONTROL, 32'h524E_4701, rs);
      chk("key resp", 32'h0, {30'h0, rs});
      wait_irq(t1);
      rdr(`OFS_IRQ_STATUS_FLAGS, rd, rs);
      chk("ready", 32'h1, rd);
      rdr(`OFS_RANDOM_OUTPUT, w1, rs);
      chk("word nonzero", 32'h1, {31'h0, w1 != 32'h0});
      chk("irq cleared", 32'h0, {31'h0, irq_o});
      rdr(`OFS_IRQ_STATUS_FLAGS, rd, rs);
      chk("flag cleared", 32'h0, rd);
      rdr(`OFS_RANDOM_OUTPUT, rd, rs);
      chk("word held", w1, rd);
      wait_irq(t2);
      chk("period", 32'd84, 32'(t2 - t1));
      rdr(`OFS_RANDOM_OUTPUT, rd, rs);
      chk("fresh word", 32'h1, {31'h0, rd !== w1});
      wr(`OFS_IRQ_ENABLE_CLEAR, 32'hFFFF_FFFE, rs);
      rdr(`OFS_IRQ_MASK_VIEW, rd, rs);
      chk("mask zero clr", 32'h1, rd);
      wr(`OFS_IRQ_ENABLE_CLEAR, 32'h1, rs);
      rdr(`OFS_IRQ_MASK_VIEW, rd, rs);
      chk("mask clr", 32'h0, rd);
      chk("irq masked", 32'h0, {31'h0, irq_o});
      rdr(`OFS_IRQ_STATUS_FLAGS, rd, rs);
      chk("masked flag", 32'h1, rd);
      repeat (90) @(posedge ref_clk_i);
      chk("irq masked late", 32'h0, {31'h0, irq_o});
      wr(`OFS_KEYED_CONTROL, 32'h524E_4700, rs);
      repeat (2) @(posedge ref_clk_i);
      rdr(`OFS_IRQ_STATUS_FLAGS, rd, rs);
      chk("disabled", 32'h0, rd);
      repeat (100) @(posedge ref_clk_i);
      rdr(`OFS_IRQ_STATUS_FLAGS, rd, rs);
      chk("halted", 32'h0, rd);
      wr(`OFS_IRQ_ENABLE_SET, 32'h1, rs);
      wr(`OFS_KEYED_CONTROL, 32'h524E_4701, rs);
      t1 = cyc;
      wait_irq(t2);
      t2 = t2 - t1;
      chk("restart", 32'h1, {31'h0, t2 >= 84 && t2 <= 88});
      results();
   end
endmodule
